//--- rtl/nvsr_top.sv
`timescale 1ns/1ns
module nvsr_top import nvsr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  input wire logic write_guard_n_i,
  input wire logic nv_busy_i,
  output logic [16:0] mem_raddr_o,
  input wire logic [7:0] mem_rdata_i,
  output logic [16:0] mem_waddr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic nv_cmd_o,
  output logic [7:0] nv_code_o,
  output logic [7:0] status_o
);

  typedef enum logic [2:0] {
    L_OP, L_ADDR, L_DUMMY, L_RDATA, L_SROUT, L_SRIN, L_WDATA, L_IDLE
  } nvsr_lst_t;

  nvsr_stat_if st();

  // Link side, clocked by the serial clock
  logic frame_rst_n;
  logic [8:0] lk_sync;
  logic wp_n_l;
  logic [7:0] stat_l;
  logic wel_l;
  logic sr_ok;
  nvsr_lst_t state_ff;
  nvsr_lst_t nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [6:0] sh_ff;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] cmd_ff;
  logic [1:0] abyte_ff;
  logic [16:0] addr_ff;
  logic ld_ff;
  logic [7:0] tx_ff;
  logic oe_ff;
  logic wtog_ff;
  logic [16:0] wl_addr_ff;
  logic [7:0] wl_data_ff;
  nvsr_act_t act_ff;
  logic act_id_ff;
  logic [7:0] srd_ff;

  // System side
  logic [1:0] sy_sync;
  logic cs_s;
  logic wt_s;
  logic cs_d_ff;
  logic wt_d_ff;
  logic seen_ff;
  logic end_evt;
  logic mem_we_ff;
  logic [16:0] waddr_ff;
  logic [7:0] wdata_ff;
  logic nv_cmd_ff;
  logic [7:0] nv_code_ff;
  logic [7:0] status_ff;

  // Frame logic is held in reset while chip select is high, so every
  // frame starts at the opcode and nothing waits on a stopped clock
  assign frame_rst_n = rst_n_i & ~spi_cs_n_i;

  // Status and guard pin brought into the link domain
  nvsr_sync #(.W(9), .STAGES(SYNC_STAGES)) u_lsync (
    .clk_i(spi_sck_i),
    .rst_n_i(rst_n_i),
    .d_i({write_guard_n_i, st.status}),
    .q_o(lk_sync)
  );

  assign wp_n_l = lk_sync[8];
  assign stat_l = lk_sync[7:0];
  assign wel_l = stat_l[SB_WEL];
  // Guard judged once, when the opcode lands
  assign sr_ok = wel_l & ~(stat_l[SB_GEN] & ~wp_n_l);

  assign rx_byte = {sh_ff, spi_si_i};
  assign byte_done = (bit_cnt_ff == 3'h7);

  // Bit counter and input shifter on rising edges
  always_ff @(posedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_ff <= 3'h0;
      sh_ff <= 7'h00;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      sh_ff <= rx_byte[6:0];
    end
  end

  // Command decode and phase sequencing
  always_comb begin
    nxt_state = state_ff;
    if (byte_done) begin
      unique case (state_ff)
        L_OP: begin
          unique case (rx_byte)
            OP_SR_RD: nxt_state = L_SROUT;
            OP_SR_FRD: nxt_state = L_DUMMY;
            OP_SR_WR: nxt_state = sr_ok ? L_SRIN : L_IDLE;
            OP_RD, OP_FRD: nxt_state = L_ADDR;
            OP_WR: nxt_state = wel_l ? L_ADDR : L_IDLE;
            OP_SN_WR: nxt_state = wel_l ? L_WDATA : L_IDLE;
            default: nxt_state = L_IDLE;
          endcase
        end
        L_ADDR: begin
          if (abyte_ff == NV_LAST_ABYTE) begin
            if (cmd_ff == OP_RD) begin
              nxt_state = L_RDATA;
            end else if (cmd_ff == OP_FRD) begin
              nxt_state = L_DUMMY;
            end else begin
              nxt_state = L_WDATA;
            end
          end
        end
        L_DUMMY: nxt_state = (cmd_ff == OP_SR_FRD) ? L_SROUT : L_RDATA;
        L_SRIN: nxt_state = L_IDLE;
        default: nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_ff <= L_OP;
      cmd_ff <= 8'h00;
      abyte_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (byte_done && state_ff == L_OP) begin
        cmd_ff <= rx_byte;
      end
      if (byte_done && state_ff == L_ADDR) begin
        abyte_ff <= abyte_ff + 2'h1;
      end
    end
  end

  // Address: shifted in, then advanced per data byte; 17 bits wrap to zero
  always_ff @(posedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      addr_ff <= 17'h00000;
    end else if (state_ff == L_ADDR) begin
      addr_ff <= {addr_ff[15:0], spi_si_i};
    end else if (byte_done && state_ff == L_RDATA) begin
      addr_ff <= addr_ff + 17'h00001;
    end else if (byte_done && state_ff == L_WDATA && cmd_ff == OP_WR) begin
      addr_ff <= addr_ff + 17'h00001;
    end
  end

  // Load request for the falling edge that follows a finished byte
  always_ff @(posedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ld_ff <= 1'b0;
    end else begin
      ld_ff <= byte_done && (nxt_state == L_RDATA || nxt_state == L_SROUT);
    end
  end

  // Output shifter on falling edges; status repeats while clocked
  always_ff @(negedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else if (ld_ff) begin
      tx_ff <= (state_ff == L_SROUT) ? stat_l : mem_rdata_i;
      oe_ff <= 1'b1;
    end else begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  assign spi_so_o = tx_ff[7];
  assign spi_so_oe_o = oe_ff;
  assign mem_raddr_o = addr_ff;

  // Accepted array bytes: held until the next one, so the slow side can
  // copy them after seeing the toggle; not cleared at frame end
  always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wtog_ff <= 1'b0;
      wl_addr_ff <= 17'h00000;
      wl_data_ff <= 8'h00;
    end else if (byte_done && state_ff == L_WDATA && cmd_ff == OP_WR
                 && !nvsr_guarded(addr_ff, stat_l[SB_BG_HI:SB_BG_LO])) begin
      wtog_ff <= ~wtog_ff;
      wl_addr_ff <= addr_ff;
      wl_data_ff <= rx_byte;
    end
  end

  // Frame action, read by the system side only after chip select rises
  always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_ff <= ACT_NONE;
      act_id_ff <= 1'b0;
      srd_ff <= 8'h00;
    end else if (byte_done) begin
      if (state_ff == L_OP) begin
        act_id_ff <= ~act_id_ff;
        srd_ff <= rx_byte; // Opcode kept past frame end for the nv code
        if (rx_byte == OP_LSET) begin
          act_ff <= ACT_LSET;
        end else if (rx_byte == OP_LCLR) begin
          act_ff <= ACT_LCLR;
        end else if (wel_l && (rx_byte == OP_STORE || rx_byte == OP_RECALL
                     || rx_byte == OP_AS_ON || rx_byte == OP_AS_OFF)) begin
          act_ff <= ACT_NV;
        end else begin
          act_ff <= ACT_NONE;
        end
      end else if (state_ff == L_SRIN) begin
        act_ff <= ACT_SRWR;
        srd_ff <= rx_byte;
      end else if (state_ff == L_WDATA) begin
        act_ff <= ACT_WDONE;
      end
    end
  end

  // Select inverted so the reset value means idle; no false frame end
  nvsr_sync #(.W(2), .STAGES(SYNC_STAGES)) u_ssync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({~spi_cs_n_i, wtog_ff}),
    .q_o(sy_sync)
  );

  assign cs_s = ~sy_sync[1];
  assign wt_s = sy_sync[0];
  assign end_evt = cs_s & ~cs_d_ff;

  // Edge history; a frame is applied once, and a frame with no opcode byte inside it is not applied
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_d_ff <= 1'b1;
      wt_d_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      cs_d_ff <= cs_s;
      wt_d_ff <= wt_s;
      if (end_evt) begin
        seen_ff <= act_id_ff;
      end
    end
  end

  assign st.apply = end_evt & (act_id_ff != seen_ff);
  assign st.act = act_ff;
  assign st.sr_data = srd_ff;
  assign st.busy = nv_busy_i;

  nvsr_status u_status (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .st(st)
  );

  // Array write strobe, one system cycle per accepted byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_we_ff <= 1'b0;
      waddr_ff <= 17'h00000;
      wdata_ff <= 8'h00;
    end else begin
      mem_we_ff <= wt_s ^ wt_d_ff;
      if (wt_s ^ wt_d_ff) begin
        waddr_ff <= wl_addr_ff;
        wdata_ff <= wl_data_ff;
      end
    end
  end

  // Nonvolatile request pulse for the store and recall engine
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_cmd_ff <= 1'b0;
      nv_code_ff <= 8'h00;
    end else begin
      nv_cmd_ff <= st.apply && act_ff == ACT_NV;
      if (st.apply && act_ff == ACT_NV) begin
        nv_code_ff <= srd_ff; // Opcode register is frame-reset by now
      end
    end
  end

  // Status copy for the user side
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= st.status;
    end
  end

  assign mem_we_o = mem_we_ff;
  assign mem_waddr_o = waddr_ff;
  assign mem_wdata_o = wdata_ff;
  assign nv_cmd_o = nv_cmd_ff;
  assign nv_code_o = nv_code_ff;
  assign status_o = status_ff;

endmodule

//--- rtl/nvsr_pkg.sv
package nvsr_pkg;

  // Array geometry
  localparam int NV_ADDR_W = 17;
  localparam int NV_ADDR_BYTES = 3;
  localparam logic [1:0] NV_LAST_ABYTE = 2'h2;
  localparam int SYNC_STAGES = 2;

  // Serial clock ceilings, for reference by the host side
  localparam int SCK_NORM_MAX_MHZ = 40;
  localparam int SCK_FAST_MAX_MHZ = 104;

  // Status and latch opcodes
  localparam logic [7:0] OP_SR_RD = 8'h05;
  localparam logic [7:0] OP_SR_FRD = 8'h09;
  localparam logic [7:0] OP_SR_WR = 8'h01;
  localparam logic [7:0] OP_LSET = 8'h06;
  localparam logic [7:0] OP_LCLR = 8'h04;
  // Array opcodes
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0b;
  localparam logic [7:0] OP_WR = 8'h02;
  // Nonvolatile and serial-number opcodes, only gated here
  localparam logic [7:0] OP_STORE = 8'h3c;
  localparam logic [7:0] OP_RECALL = 8'h60;
  localparam logic [7:0] OP_AS_ON = 8'h59;
  localparam logic [7:0] OP_AS_OFF = 8'h19;
  localparam logic [7:0] OP_SN_WR = 8'hc2;

  // Status byte layout
  localparam int SB_RDY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BG_LO = 2;
  localparam int SB_BG_HI = 3;
  localparam int SB_SLOCK = 6;
  localparam int SB_GEN = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Guarded region bases
  localparam logic [16:0] BG_QTR_BASE = 17'h18000;
  localparam logic [16:0] BG_HALF_BASE = 17'h10000;

  // Action handed from the link side at frame end
  typedef enum logic [2:0] {
    ACT_NONE, ACT_LSET, ACT_LCLR, ACT_SRWR, ACT_WDONE, ACT_NV
  } nvsr_act_t;

  // True when the address sits in the region picked by the guard bits
  function automatic logic nvsr_guarded(input logic [16:0] a, input logic [1:0] bg);
    unique case (bg)
      2'h0: nvsr_guarded = 1'b0;
      2'h1: nvsr_guarded = (a >= BG_QTR_BASE);
      2'h2: nvsr_guarded = (a >= BG_HALF_BASE);
      default: nvsr_guarded = 1'b1;
    endcase
  endfunction

endpackage

//--- rtl/nvsr_stat_if.sv
`timescale 1ns/1ns
interface nvsr_stat_if import nvsr_pkg::*; ();
  logic [7:0] status;
  nvsr_act_t act;
  logic [7:0] sr_data;
  logic apply;
  logic busy;
  modport keeper(input act, input sr_data, input apply, input busy, output status);
  modport user(output act, output sr_data, output apply, output busy, input status);
endinterface

//--- rtl/nvsr_sync.sv
`timescale 1ns/1ns
module nvsr_sync import nvsr_pkg::*; #(
  parameter int W = 1,
  parameter int STAGES = SYNC_STAGES
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] stg_ff [STAGES];

  // Plain flop chain; only the last stage is ever read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stg_ff[i] <= '0;
      end
    end else begin
      stg_ff[0] <= d_i;
      for (int i = 1; i < STAGES; i++) begin
        stg_ff[i] <= stg_ff[i-1];
      end
    end
  end

  assign q_o = stg_ff[STAGES-1];

endmodule

//--- rtl/nvsr_status.sv
`timescale 1ns/1ns
module nvsr_status import nvsr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  nvsr_stat_if.keeper st
);

  logic rdy_ff;
  logic wel_ff;
  logic [1:0] bg_ff;
  logic slock_ff;
  logic gen_ff;

  // Busy mirror of the nonvolatile engine
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_ff <= STATUS_RST[SB_RDY];
    end else begin
      rdy_ff <= st.busy;
    end
  end

  // Latch: set by its command, cleared by every finished write-type command
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wel_ff <= STATUS_RST[SB_WEL];
    end else if (st.apply) begin
      unique case (st.act)
        ACT_LSET: wel_ff <= 1'b1;
        ACT_LCLR: wel_ff <= 1'b0;
        ACT_SRWR, ACT_WDONE, ACT_NV: wel_ff <= 1'b0;
        default: wel_ff <= wel_ff;
      endcase
    end
  end

  // Writable fields; lock bit can only ever be set
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bg_ff <= STATUS_RST[SB_BG_HI:SB_BG_LO];
      slock_ff <= STATUS_RST[SB_SLOCK];
      gen_ff <= STATUS_RST[SB_GEN];
    end else if (st.apply && st.act == ACT_SRWR) begin
      bg_ff <= st.sr_data[SB_BG_HI:SB_BG_LO];
      slock_ff <= slock_ff | st.sr_data[SB_SLOCK];
      gen_ff <= st.sr_data[SB_GEN];
    end
  end

  // Bits 5..4 read as zero
  assign st.status = {gen_ff, slock_ff, 2'b00, bg_ff, wel_ff, rdy_ff};

endmodule

//--- testbench/nvsr_top_props.sv
`timescale 1ns/1ns
module nvsr_top_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_so_oe_o,
  input wire logic nv_busy_i,
  input wire logic [16:0] mem_waddr_o,
  input wire logic mem_we_o,
  input wire logic nv_cmd_o,
  input wire logic [7:0] status_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Region test written out here, not borrowed from the package helper
  logic [1:0] bg;
  logic hit;
  assign bg = status_o[3:2];
  assign hit = bg == 2'h3 || (bg == 2'h2 && mem_waddr_o >= 17'h10000)
    || (bg == 2'h1 && mem_waddr_o >= 17'h18000);

  a_pad_bits_zero: assert property (status_o[5:4] == 2'h0)
    else $error("status pad bits not zero");
  a_ready_high: assert property (nv_busy_i [*3] |-> status_o[0])
    else $error("ready bit low while busy");
  a_ready_low: assert property (!nv_busy_i [*3] |-> !status_o[0])
    else $error("ready bit high while idle");
  a_oe_idle: assert property (spi_cs_n_i |-> !spi_so_oe_o)
    else $error("serial output driven while deselected");
  a_we_needs_wel: assert property (mem_we_o |-> status_o[1])
    else $error("array write without latch");
  a_we_guarded: assert property (mem_we_o |-> !hit)
    else $error("array write into guarded region");
  a_we_single: assert property (mem_we_o |=> !mem_we_o)
    else $error("write strobe longer than one cycle");
  a_nv_gated: assert property (nv_cmd_o |-> status_o[1] ##1 !nv_cmd_o)
    else $error("nv command without latch or too long");
  a_wel_rise: assert property ($rose(status_o[1]) |-> spi_cs_n_i)
    else $error("latch set inside a frame");
  a_wel_fall: assert property ($fell(status_o[1]) |-> spi_cs_n_i)
    else $error("latch cleared inside a frame");

  // Main traffic kinds seen at least once
  c_we: cover property (mem_we_o);
  c_nv: cover property (nv_cmd_o);
  c_ready: cover property (status_o[0]);
  c_oe: cover property (spi_so_oe_o);
endmodule

bind nvsr_top nvsr_top_props i_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_so_oe_o(spi_so_oe_o), .nv_busy_i(nv_busy_i), .mem_waddr_o(mem_waddr_o),
  .mem_we_o(mem_we_o), .nv_cmd_o(nv_cmd_o), .status_o(status_o)
);

//--- testbench/nvsr_host_model.sv
`timescale 1ns/1ns
// Host controller; its clock runs only inside frames
module nvsr_host_model (
  output logic spi_sck_o,
  output logic spi_cs_n_o,
  output logic spi_si_o,
  input wire logic spi_so_i
);
  logic idle_hi;

  initial begin
    idle_hi = 1'b0;
    spi_sck_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_si_o = 1'b1;
  end

  // Odd offset keeps the link out of step with the system clock
  task automatic open_frame(input logic mode3);
    idle_hi = mode3;
    spi_sck_o = mode3;
    #7;
    spi_cs_n_o = 1'b0;
    #9;
  endtask

  // Whole bytes only, MSB first; 32 ns period stays under the slow ceiling
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_sck_o = 1'b0;
      spi_si_o = tx[i];
      #16;
      spi_sck_o = 1'b1;
      rx[i] = spi_so_i;
      #16;
    end
  endtask

  // Deselect right after the last bit; stale data is not left on the line
  task automatic close_frame();
    spi_sck_o = idle_hi;
    #16;
    spi_cs_n_o = 1'b1;
    spi_si_o = ~spi_si_o;
    #150;
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ns
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wg_n = 1'b1;
  logic busy = 1'b0;
  logic sck, cs_n, si, so, so_oe, we, nv_cmd;
  logic [16:0] raddr, waddr;
  logic [7:0] wdata, nv_code, status, rx;
  logic [7:0] mem [0:131071];
  logic [16:0] pts [5] = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000, 17'h1ffff};
  logic [7:0] nvops [4] = '{8'h3c, 8'h60, 8'h59, 8'h19};
  int err_count = 0;
  int compares = 0;
  int nv_cnt = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  // Array storage with asynchronous read; nv pulses counted
  always @(posedge sys_clk_i) begin
    if (we === 1'b1) begin
      mem[waddr] <= wdata;
    end
    if (nv_cmd === 1'b1) begin
      nv_cnt <= nv_cnt + 1;
    end
  end

  nvsr_top i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .spi_sck_i(sck),
    .spi_cs_n_i(cs_n),
    .spi_si_i(si),
    .spi_so_o(so),
    .spi_so_oe_o(so_oe),
    .write_guard_n_i(wg_n),
    .nv_busy_i(busy),
    .mem_raddr_o(raddr),
    .mem_rdata_i(mem[raddr]),
    .mem_waddr_o(waddr),
    .mem_wdata_o(wdata),
    .mem_we_o(we),
    .nv_cmd_o(nv_cmd),
    .nv_code_o(nv_code),
    .status_o(status)
  );

  nvsr_host_model i_host (
    .spi_sck_o(sck),
    .spi_cs_n_o(cs_n),
    .spi_si_o(si),
    .spi_so_i(so)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic prot(input logic [1:0] b, input logic [16:0] a);
    return b == 2'h3 || (b == 2'h2 && a >= 17'h10000) || (b == 2'h1 && a >= 17'h18000);
  endfunction

  // Pin moves just after a system edge
  task automatic set_pin(input logic v);
    @(posedge sys_clk_i);
    #1;
    wg_n = v;
  endtask

  task automatic cmd(input logic [7:0] op);
    i_host.open_frame(1'b0);
    i_host.xfer(op, rx);
    i_host.close_frame();
  endtask

  // Optional pin fall after the opcode, while still selected
  task automatic wr_sr(input logic [7:0] v, input logic drop);
    i_host.open_frame(1'b0);
    i_host.xfer(8'h01, rx);
    if (drop) begin
      set_pin(1'b0);
    end
    i_host.xfer(v, rx);
    i_host.close_frame();
  endtask

  task automatic rd_sr(input logic fast, input logic [7:0] exp);
    i_host.open_frame(fast);
    i_host.xfer(fast ? 8'h09 : 8'h05, rx);
    if (fast) begin
      i_host.xfer(8'hff, rx);
    end
    i_host.xfer(8'h00, rx);
    chk(rx, exp);
    chk(so_oe, 1'b1);
    i_host.close_frame();
  endtask

  // Top address byte carries junk above A16; reads compare every byte
  task automatic arr(input logic [7:0] op, input logic [16:0] a, input int n,
      input logic [7:0] d, input logic m3);
    logic [16:0] ea;
    i_host.open_frame(m3);
    i_host.xfer(op, rx);
    i_host.xfer({7'h55, a[16]}, rx);
    i_host.xfer(a[15:8], rx);
    i_host.xfer(a[7:0], rx);
    if (op == 8'h0b) begin
      i_host.xfer(8'ha5, rx);
    end
    for (int k = 0; k < n; k++) begin
      ea = a + 17'(k);
      i_host.xfer(d + 8'(k), rx);
      if (op != 8'h02) begin
        chk(rx, mem[ea]);
      end
    end
    i_host.close_frame();
  endtask

  task automatic set_bg(input logic [1:0] b);
    cmd(8'h06);
    wr_sr({4'h0, b, 2'h0}, 1'b0);
    chk(status, {4'h0, b, 2'h0});
  endtask

  initial begin
    logic [7:0] prev;
    for (int i = 0; i < 131072; i++) begin
      mem[i] = 8'(i);
    end
    repeat (12) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk(status, 8'h00);
    cmd(8'h06);
    rd_sr(1'b0, 8'h02);
    rd_sr(1'b1, 8'h02);
    cmd(8'h04);
    chk(status, 8'h00);
    wr_sr(8'hbf, 1'b0);
    chk(status, 8'h00);
    cmd(8'h06);
    wr_sr(8'hbf, 1'b0);
    chk(status, 8'h8c);
    chk(so_oe, 1'b0);
    set_pin(1'b0);
    cmd(8'h06);
    wr_sr(8'h00, 1'b0);
    chk(status[7:2], 6'h23);
    set_pin(1'b1);
    cmd(8'h06);
    wr_sr(8'h00, 1'b1);
    chk(status, 8'h00);
    cmd(8'h06);
    wr_sr(8'h04, 1'b0);
    chk(status, 8'h04);
    set_pin(1'b1);
    // Each guard level against both sides of every region edge
    for (int b = 0; b < 4; b++) begin
      set_bg(2'(b));
      for (int j = 0; j < 5; j++) begin
        prev = mem[pts[j]];
        cmd(8'h06);
        arr(8'h02, pts[j], 1, {2'(b), 3'(j), 3'h5}, 1'b0);
        chk(mem[pts[j]], prot(2'(b), pts[j]) ? prev : {2'(b), 3'(j), 3'h5});
        chk(status[1], 1'b0);
      end
    end
    set_bg(2'h1);
    prev = mem[17'h1ffff];
    cmd(8'h06);
    arr(8'h02, 17'h1ffff, 2, 8'h77, 1'b0);
    chk(mem[17'h1ffff], prev);
    chk(mem[17'h00000], 8'h78);
    arr(8'h02, 17'h00100, 1, 8'h11, 1'b0);
    chk(mem[17'h00100], 8'h00);
    arr(8'h03, 17'h1fffe, 3, 8'h00, 1'b0);
    arr(8'h0b, 17'h1ffff, 2, 8'h00, 1'b1);
    for (int j = 0; j < 4; j++) begin
      cmd(8'h06);
      cmd(nvops[j]);
      chk(nv_cnt, j + 1);
      chk(nv_code, nvops[j]);
      chk(status[1], 1'b0);
    end
    cmd(8'h3c);
    chk(nv_cnt, 4);
    // Busy cycle: poll status only, no array traffic meanwhile
    @(posedge sys_clk_i);
    #1;
    busy = 1'b1;
    rd_sr(1'b0, 8'h05);
    @(posedge sys_clk_i);
    #1;
    busy = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk(status, 8'h04);
    final_report();
  end
endmodule
